// ===== design/motion_cfg.sv
// Low-power, motion-wake, queue-enable and frame-sync logic of the motion sensor
//
// Behaviour
// (RULE1) Gyro duty-cycle bit 7 duty-cycles gyro or 6-axis path; resets to zero.
// (RULE2) Three-bit gyro averaging select at bits 6:4, reset zero, used during duty-cycling.
// (RULE3) Averaging codes 0..7 give 1,2,4,...,128 samples.
// (RULE4) During gyro duty-cycling the normal low-pass setting is ignored.
// (RULE5) Wake rate codes 4..11 give 3.9 Hz doubling to 500 Hz; others reserved.
// (RULE6) Wake rate applies only with gyro off and accel duty-cycle set.
// (RULE7) Eight-bit read/write wake threshold compared by the wake-on-motion check.
// (RULE8) One threshold count is 4 mg regardless of full scale.
// (RULE9) Temperature queue enable pushes temperature high then low each sample tick; a tick that arrives during a burst is dropped here.
// (RULE10) Gyro X, Y, Z enables each push that axis high and low bytes.
// (RULE11) Enabled sources are queued even when their data path is in standby.
// (RULE12) Accel queue enable pushes six accel bytes, high then low per axis.
// (RULE13) Frame-sync flag is set by hardware on each frame-sync interrupt.
// (RULE14) Reading the frame-sync status register clears the flag.
// (RULE15) Host turns gyro off and sets accel duty-cycle for wake mode.
// (RULE16) Sample tick is the filter rate divided by one plus divider.
// (RULE17) Frame-sync irq enable lets pin transition to active level raise interrupt.
// (RULE18) Bytes of one tick go out in ascending register order, high first.
// (RULE19) Reserved bits read zero and writes to them are dropped.
// (RULE20) Reserved wake rate codes are ignored; previous valid rate is kept.
`timescale 1ns/1ns
`default_nettype none
module motion_cfg
	import motion_cfg_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire reg_req_t reg_req_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [2:0] gyro_lowpass_sel_i,
	input wire logic gyro_off_i,
	input wire logic accel_cycle_i,
	input wire logic [7:0] accel_delta_i,
	output logic gyro_duty_cycle_o,
	output logic [7:0] gyro_avg_samples_o,
	output logic [2:0] gyro_lowpass_eff_o,
	output logic motion_wake_active_o,
	output logic [3:0] motion_wake_rate_sel_o,
	output logic [2:0] motion_wake_rate_shift_o,
	output logic motion_wake_hit_o,
	input wire logic filter_tick_i,
	input wire logic [7:0] sample_rate_divider_i,
	input wire sensor_sample_t sample_i,
	output logic sample_tick_o,
	output logic queue_wr_o,
	output logic [7:0] queue_data_o,
	input wire logic frame_sync_input_i,
	input wire logic frame_sync_irq_en_i,
	input wire logic frame_sync_active_low_i,
	output logic frame_sync_flag_o
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic slot_enabled(input logic [3:0] slot, input logic [7:0] en);
		logic res;
		res = en[GYRO_Z_QUEUE_BIT];
		if (slot < SLOT_ACCEL_END) begin
			res = en[ACCEL_QUEUE_BIT];
		end else if (slot < SLOT_TEMP_END) begin
			res = en[TEMP_QUEUE_BIT];
		end else if (slot < SLOT_GYRO_X_END) begin
			res = en[GYRO_X_QUEUE_BIT];
		end else if (slot < SLOT_GYRO_Y_END) begin
			res = en[GYRO_Y_QUEUE_BIT];
		end
		return res;
	endfunction

	function automatic logic rate_valid(input logic [3:0] code);
		return (code >= WAKE_RATE_MIN) && (code <= WAKE_RATE_MAX);
	endfunction

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [7:0] lp_cfg_r, lp_cfg_nxt;
	logic [7:0] thr_r, thr_nxt;
	logic [7:0] qen_r, qen_nxt;
	logic fs_flag_r, fs_flag_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic [3:0] wake_rate_r, wake_rate_nxt;
	logic fs_evt;

	always_comb begin
		lp_cfg_nxt = lp_cfg_r;
		thr_nxt = thr_r;
		qen_nxt = qen_r;
		rdata_nxt = 8'h00;
		fs_flag_nxt = fs_flag_r;
		wake_rate_nxt = wake_rate_r;
		if (reg_req_i.wr) begin
			case (reg_req_i.addr)
				LOW_POWER_MODE_CONFIG_ADDR: lp_cfg_nxt = reg_req_i.wdata; // [RULE1] [RULE2]
				MOTION_WAKE_THRESHOLD_ADDR: thr_nxt = reg_req_i.wdata; // [RULE7]
				QUEUE_SOURCE_ENABLE_ADDR: qen_nxt = reg_req_i.wdata & QUEUE_ENABLE_MASK; // [RULE19]
				default: ;
			endcase
		end
		if (reg_req_i.rd) begin
			case (reg_req_i.addr)
				LOW_POWER_MODE_CONFIG_ADDR: rdata_nxt = lp_cfg_r;
				MOTION_WAKE_THRESHOLD_ADDR: rdata_nxt = thr_r;
				QUEUE_SOURCE_ENABLE_ADDR: rdata_nxt = qen_r;
				FRAME_SYNC_IRQ_STATUS_ADDR: begin
					rdata_nxt = {fs_flag_r, 7'h00} & FRAME_SYNC_STATUS_MASK; // [RULE19]
					fs_flag_nxt = 1'b0; // [RULE14]
				end
				default: rdata_nxt = 8'h00;
			endcase
		end
		// Set beats the read clear so no pin event is lost
		if (fs_evt) begin
			fs_flag_nxt = 1'b1; // [RULE13]
		end
		// Reserved codes never reach the sampling logic
		if (gyro_off_i && accel_cycle_i && rate_valid(lp_cfg_r[WAKE_RATE_MSB:0])) begin
			wake_rate_nxt = lp_cfg_r[WAKE_RATE_MSB:0]; // [RULE6] [RULE20] [RULE15]
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			lp_cfg_r <= LOW_POWER_RESET;
			thr_r <= THRESHOLD_RESET;
			qen_r <= QUEUE_ENABLE_RESET;
			fs_flag_r <= 1'b0;
			rdata_r <= 8'h00;
			wake_rate_r <= WAKE_RATE_RESET;
		end else begin
			lp_cfg_r <= lp_cfg_nxt;
			thr_r <= thr_nxt;
			qen_r <= qen_nxt;
			fs_flag_r <= fs_flag_nxt;
			rdata_r <= rdata_nxt;
			wake_rate_r <= wake_rate_nxt;
		end
	end

	// ------------------------------------------------------------
	// Gyro duty-cycling and motion wake
	// ------------------------------------------------------------
	assign gyro_duty_cycle_o = lp_cfg_r[GYRO_CYCLE_BIT]; // [RULE1]
	assign gyro_avg_samples_o = 8'h01 << lp_cfg_r[GYRO_AVG_MSB:GYRO_AVG_LSB]; // [RULE3]
	assign gyro_lowpass_eff_o = lp_cfg_r[GYRO_CYCLE_BIT] ? 3'h0 : gyro_lowpass_sel_i; // [RULE4]
	assign motion_wake_active_o = gyro_off_i && accel_cycle_i; // [RULE6]
	assign motion_wake_rate_sel_o = wake_rate_r;
	// Each step above the lowest code doubles 3.9 Hz
	assign motion_wake_rate_shift_o = 3'(wake_rate_r - WAKE_RATE_MIN); // [RULE5]
	// Delta arrives in 4 mg units, so no full-scale scaling here
	assign motion_wake_hit_o = motion_wake_active_o && (accel_delta_i > thr_r); // [RULE7] [RULE8]
	assign reg_rdata_o = rdata_r;

	// ------------------------------------------------------------
	// Sample-rate divider
	// ------------------------------------------------------------
	logic [7:0] div_cnt_r, div_cnt_nxt;
	logic tick_r, tick_nxt;

	always_comb begin
		div_cnt_nxt = div_cnt_r;
		tick_nxt = 1'b0;
		if (filter_tick_i) begin
			if (div_cnt_r >= sample_rate_divider_i) begin
				div_cnt_nxt = 8'h00; // [RULE16]
				tick_nxt = 1'b1;
			end else begin
				div_cnt_nxt = div_cnt_r + 8'h01;
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div_cnt_r <= 8'h00;
			tick_r <= 1'b0;
		end else begin
			div_cnt_r <= div_cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign sample_tick_o = tick_r;

	// ------------------------------------------------------------
	// Queue writer
	// ------------------------------------------------------------
	queue_state_t qst_r, qst_nxt;
	logic [3:0] slot_r, slot_nxt;
	logic [7:0] qen_snap_r, qen_snap_nxt;
	sensor_sample_t snap_r, snap_nxt;
	logic wr_r, wr_nxt;
	logic [7:0] qdata_r, qdata_nxt;

	always_comb begin
		qst_nxt = qst_r;
		slot_nxt = slot_r;
		qen_snap_nxt = qen_snap_r;
		snap_nxt = snap_r;
		wr_nxt = 1'b0;
		qdata_nxt = qdata_r;
		case (qst_r)
			ST_IDLE: begin
				// No standby gating: enabled sources always go out
				if (tick_r && (qen_r != 8'h00)) begin
					snap_nxt = sample_i; // [RULE11]
					qen_snap_nxt = qen_r;
					slot_nxt = 4'h0;
					qst_nxt = ST_SEND;
				end
			end
			ST_SEND: begin
				// Slots follow output register order, high byte first
				wr_nxt = slot_enabled(slot_r, qen_snap_r); // [RULE9] [RULE10] [RULE12]
				qdata_nxt = snap_r[8'd111 - {slot_r, 3'h0} -: 8]; // [RULE18]
				slot_nxt = slot_r + 4'h1;
				if (slot_r == SAMPLE_SLOTS - 4'h1) begin
					qst_nxt = ST_IDLE;
				end
			end
			default: qst_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			qst_r <= ST_IDLE;
			slot_r <= 4'h0;
			qen_snap_r <= 8'h00;
			snap_r <= '0;
			wr_r <= 1'b0;
			qdata_r <= 8'h00;
		end else begin
			qst_r <= qst_nxt;
			slot_r <= slot_nxt;
			qen_snap_r <= qen_snap_nxt;
			snap_r <= snap_nxt;
			wr_r <= wr_nxt;
			qdata_r <= qdata_nxt;
		end
	end

	assign queue_wr_o = wr_r;
	assign queue_data_o = qdata_r;

	// ------------------------------------------------------------
	// Frame-sync pin
	// ------------------------------------------------------------
	logic fs_s1_r, fs_s2_r, fs_s3_r, fs_lvl_r, fs_lvl_nxt;
	always_comb begin
		fs_lvl_nxt = fs_lvl_r;
		if (fs_s2_r == fs_s3_r) begin
			fs_lvl_nxt = fs_s3_r;
		end
	end
	// Edge counted only into the configured active level
	assign fs_evt = frame_sync_irq_en_i && (fs_lvl_nxt != fs_lvl_r)
		&& (fs_lvl_nxt == !frame_sync_active_low_i); // [RULE17]
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			fs_s1_r <= 1'b0;
			fs_s2_r <= 1'b0;
			fs_s3_r <= 1'b0;
			fs_lvl_r <= 1'b0;
		end else begin
			fs_s1_r <= frame_sync_input_i;
			fs_s2_r <= fs_s1_r;
			fs_s3_r <= fs_s2_r;
			fs_lvl_r <= fs_lvl_nxt;
		end
	end

	assign frame_sync_flag_o = fs_flag_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_fs_set;
		@(posedge ref_clk_i) disable iff (sys_rst_i) fs_evt |=> fs_flag_r;
	endproperty
	a_fs_set: assert property (p_fs_set) else $error("frame-sync flag not set"); // [RULE13]
	property p_fs_clear;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		(reg_req_i.rd && reg_req_i.addr == FRAME_SYNC_IRQ_STATUS_ADDR && !fs_evt) |=> !fs_flag_r;
	endproperty
	a_fs_clear: assert property (p_fs_clear) else $error("read did not clear flag"); // [RULE14]
	property p_fs_read;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		(reg_req_i.rd && reg_req_i.addr == FRAME_SYNC_IRQ_STATUS_ADDR)
		|=> reg_rdata_o == {$past(fs_flag_r), 7'h00};
	endproperty
	a_fs_read: assert property (p_fs_read) else $error("status read wrong"); // [RULE19]
	property p_fs_noirq;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		(!frame_sync_irq_en_i && !fs_flag_r) |=> !fs_flag_r;
	endproperty
	a_fs_noirq: assert property (p_fs_noirq) else $error("flag set while disabled"); // [RULE17]
	property p_lowpass;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		gyro_duty_cycle_o |-> gyro_lowpass_eff_o == 3'h0;
	endproperty
	a_lowpass: assert property (p_lowpass) else $error("low-pass used while cycling"); // [RULE4]
	property p_rate_valid;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		rate_valid(motion_wake_rate_sel_o);
	endproperty
	a_rate_valid: assert property (p_rate_valid) else $error("reserved rate in use"); // [RULE20]
	property p_rate_hold;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		!(gyro_off_i && accel_cycle_i) |=> $stable(motion_wake_rate_sel_o);
	endproperty
	a_rate_hold: assert property (p_rate_hold) else $error("rate changed outside wake"); // [RULE6]
	property p_qen_mask;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		(reg_req_i.wr && reg_req_i.addr == QUEUE_SOURCE_ENABLE_ADDR)
		##1 (reg_req_i.rd && reg_req_i.addr == QUEUE_SOURCE_ENABLE_ADDR && !reg_req_i.wr)
		|=> reg_rdata_o == ($past(reg_req_i.wdata, 2) & QUEUE_ENABLE_MASK);
	endproperty
	a_qen_mask: assert property (p_qen_mask) else $error("queue enable readback"); // [RULE19]
	property p_accel_burst;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		(qst_r == ST_IDLE && tick_r && qen_r == 8'h08) |=> ##1 queue_wr_o [*6] ##1 !queue_wr_o;
	endproperty
	a_accel_burst: assert property (p_accel_burst) else $error("accel burst length"); // [RULE12]
	property p_tick_div;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
		sample_tick_o |-> $past(filter_tick_i) && $past(div_cnt_r) >= $past(sample_rate_divider_i);
	endproperty
	a_tick_div: assert property (p_tick_div) else $error("tick without divider wrap"); // [RULE16]
	c_fs_event: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) fs_evt);
	c_burst: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) queue_wr_o [*2]);
	c_wake_hit: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) motion_wake_hit_o);
	c_set_and_clear: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		fs_evt && reg_req_i.rd && reg_req_i.addr == FRAME_SYNC_IRQ_STATUS_ADDR);
endmodule
`default_nettype wire

// ===== design/motion_cfg_pkg.sv
// Shared constants and types for the motion sensor configuration block
package motion_cfg_pkg;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] LOW_POWER_MODE_CONFIG_ADDR = 8'h1E;
	localparam logic [7:0] MOTION_WAKE_THRESHOLD_ADDR = 8'h1F;
	localparam logic [7:0] QUEUE_SOURCE_ENABLE_ADDR = 8'h23;
	localparam logic [7:0] FRAME_SYNC_IRQ_STATUS_ADDR = 8'h36;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int GYRO_CYCLE_BIT = 7;
	localparam int GYRO_AVG_MSB = 6;
	localparam int GYRO_AVG_LSB = 4;
	localparam int WAKE_RATE_MSB = 3;
	localparam int TEMP_QUEUE_BIT = 7;
	localparam int GYRO_X_QUEUE_BIT = 6;
	localparam int GYRO_Y_QUEUE_BIT = 5;
	localparam int GYRO_Z_QUEUE_BIT = 4;
	localparam int ACCEL_QUEUE_BIT = 3;
	localparam int FRAME_SYNC_FLAG_BIT = 7;
	localparam logic [7:0] QUEUE_ENABLE_MASK = 8'hF8;
	localparam logic [7:0] FRAME_SYNC_STATUS_MASK = 8'h80;
	localparam logic [7:0] LOW_POWER_RESET = 8'h00;
	localparam logic [7:0] THRESHOLD_RESET = 8'h00;
	localparam logic [7:0] QUEUE_ENABLE_RESET = 8'h00;
	localparam logic [3:0] WAKE_RATE_MIN = 4'h4;
	localparam logic [3:0] WAKE_RATE_MAX = 4'hB;
	localparam logic [3:0] WAKE_RATE_RESET = 4'h4;
	localparam logic [3:0] SAMPLE_SLOTS = 4'hE;
	localparam logic [3:0] SLOT_ACCEL_END = 4'h6;
	localparam logic [3:0] SLOT_TEMP_END = 4'h8;
	localparam logic [3:0] SLOT_GYRO_X_END = 4'hA;
	localparam logic [3:0] SLOT_GYRO_Y_END = 4'hC;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] accel_x;
		logic [15:0] accel_y;
		logic [15:0] accel_z;
		logic [15:0] temp;
		logic [15:0] gyro_x;
		logic [15:0] gyro_y;
		logic [15:0] gyro_z;
	} sensor_sample_t;

	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} reg_req_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_SEND = 2'b10
	} queue_state_t;
endpackage

// ===== testbench/motion_host_model.sv
// Host processor model issuing register requests to the motion block
`timescale 1ns/1ns
`default_nettype none
module motion_host_model
	import motion_cfg_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic [7:0] reg_rdata_i,
	output var reg_req_t reg_req_o
);
	initial begin
		reg_req_o = '{addr: 8'h00, wr: 1'b0, rd: 1'b0, wdata: 8'h00};
	end
	// Idle bus shows inverted leftovers so a stale request never looks valid
	task automatic release_bus();
		reg_req_o = '{addr: ~reg_req_o.addr, wr: 1'b0, rd: 1'b0, wdata: ~reg_req_o.wdata};
	endtask
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(negedge ref_clk_i);
		reg_req_o = '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
		@(negedge ref_clk_i);
		release_bus();
	endtask
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(negedge ref_clk_i);
		reg_req_o = '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: ~reg_req_o.wdata};
		// Read data stands only in the cycle after the strobe
		@(negedge ref_clk_i);
		data = reg_rdata_i;
		release_bus();
	endtask
	// Write then read of one register in consecutive cycles
	task automatic write_read(input logic [7:0] addr, input logic [7:0] wdat,
		output logic [7:0] data);
		@(negedge ref_clk_i);
		reg_req_o = '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: wdat};
		@(negedge ref_clk_i);
		reg_req_o = '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: ~wdat};
		@(negedge ref_clk_i);
		data = reg_rdata_i;
		release_bus();
	endtask
endmodule
`default_nettype wire

// ===== testbench/motion_cfg_tb.sv
// Self-checking testbench for the motion sensor configuration block
`timescale 1ns/1ns
`default_nettype none
module motion_cfg_tb
	import motion_cfg_pkg::*;
;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	reg_req_t reg_req;
	logic [7:0] reg_rdata;
	logic [2:0] lowpass_sel = 3'h5;
	logic gyro_off = 1'b0;
	logic accel_cycle = 1'b0;
	logic [7:0] accel_delta = 8'h00;
	logic gyro_duty, wake_active, wake_hit, sample_tick, queue_wr, fs_flag;
	logic [7:0] avg_samples, queue_data;
	logic [2:0] lowpass_eff, rate_shift;
	logic [3:0] rate_sel;
	logic filter_tick = 1'b0;
	logic [7:0] divider = 8'h03;
	sensor_sample_t sample = 112'h0102_0304_0506_0708_090A_0B0C_0D0E;
	logic fs_pin = 1'b0;
	logic fs_en = 1'b0;
	logic fs_low = 1'b0;
	int err_count = 0;
	int num_checks = 0;
	int tick_count = 0;
	logic [7:0] got_q[$];

	motion_cfg u_motion_cfg (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_req_i(reg_req),
		.reg_rdata_o(reg_rdata), .gyro_lowpass_sel_i(lowpass_sel), .gyro_off_i(gyro_off),
		.accel_cycle_i(accel_cycle), .accel_delta_i(accel_delta),
		.gyro_duty_cycle_o(gyro_duty), .gyro_avg_samples_o(avg_samples),
		.gyro_lowpass_eff_o(lowpass_eff), .motion_wake_active_o(wake_active),
		.motion_wake_rate_sel_o(rate_sel), .motion_wake_rate_shift_o(rate_shift),
		.motion_wake_hit_o(wake_hit), .filter_tick_i(filter_tick),
		.sample_rate_divider_i(divider), .sample_i(sample), .sample_tick_o(sample_tick),
		.queue_wr_o(queue_wr), .queue_data_o(queue_data), .frame_sync_input_i(fs_pin),
		.frame_sync_irq_en_i(fs_en), .frame_sync_active_low_i(fs_low),
		.frame_sync_flag_o(fs_flag)
	);
	motion_host_model u_motion_host_model (
		.ref_clk_i(ref_clk_i), .reg_rdata_i(reg_rdata), .reg_req_o(reg_req)
	);

	initial begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end
	// Sampled mid-cycle, where the registered outputs have settled
	always @(negedge ref_clk_i) begin
		if (queue_wr === 1'b1) got_q.push_back(queue_data);
		if (sample_tick === 1'b1) tick_count++;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic rd_chk(input string name, input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] v;
		u_motion_host_model.read_reg(addr, v);
		check(name, v, exp);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic test_reset();
		rd_chk("lp_cfg", LOW_POWER_MODE_CONFIG_ADDR, 8'h00);
		rd_chk("threshold", MOTION_WAKE_THRESHOLD_ADDR, 8'h00);
		rd_chk("queue_en", QUEUE_SOURCE_ENABLE_ADDR, 8'h00);
		rd_chk("fs_status", FRAME_SYNC_IRQ_STATUS_ADDR, 8'h00);
		rd_chk("unmapped", 8'h20, 8'h00);
		check("avg_samples", avg_samples, 8'h01);
		check("rate_sel", {4'h0, rate_sel}, 8'h04);
		$display("test reset done");
	endtask
	task automatic test_low_power();
		logic [7:0] v;
		for (int c = 0; c < 8; c++) begin
			v = 8'h80 | 8'(c << 4) | 8'h0B;
			u_motion_host_model.write_reg(LOW_POWER_MODE_CONFIG_ADDR, v);
			rd_chk("lp_cfg", LOW_POWER_MODE_CONFIG_ADDR, v);
			check("duty", {7'h00, gyro_duty}, 8'h01);
			check("avg_samples", avg_samples, 8'(1 << c));
			check("lp_eff", {5'h00, lowpass_eff}, 8'h00);
		end
		u_motion_host_model.write_reg(LOW_POWER_MODE_CONFIG_ADDR, 8'h04);
		check("duty", {7'h00, gyro_duty}, 8'h00);
		check("lp_eff", {5'h00, lowpass_eff}, 8'h05);
		$display("test low power done");
	endtask
	task automatic test_wake_rate();
		logic [3:0] exp_rate;
		exp_rate = 4'h4;
		gyro_off = 1'b1;
		accel_cycle = 1'b1;
		for (int c = 0; c < 16; c++) begin
			if (c >= 4 && c <= 11) exp_rate = 4'(c);
			u_motion_host_model.write_reg(LOW_POWER_MODE_CONFIG_ADDR, 8'(c));
			rd_chk("lp_cfg", LOW_POWER_MODE_CONFIG_ADDR, 8'(c));
			check("rate_sel", {4'h0, rate_sel}, {4'h0, exp_rate});
			check("rate_shift", {5'h00, rate_shift}, 8'(exp_rate - 4'h4));
		end
		check("wake_active", {7'h00, wake_active}, 8'h01);
		gyro_off = 1'b0;
		u_motion_host_model.write_reg(LOW_POWER_MODE_CONFIG_ADDR, 8'h06);
		rd_chk("lp_cfg", LOW_POWER_MODE_CONFIG_ADDR, 8'h06);
		check("rate_sel", {4'h0, rate_sel}, 8'h0B);
		check("wake_active", {7'h00, wake_active}, 8'h00);
		$display("test wake rate done");
	endtask
	task automatic test_threshold();
		u_motion_host_model.write_reg(MOTION_WAKE_THRESHOLD_ADDR, 8'h10);
		rd_chk("threshold", MOTION_WAKE_THRESHOLD_ADDR, 8'h10);
		gyro_off = 1'b1;
		accel_delta = 8'h10;
		@(negedge ref_clk_i);
		check("hit", {7'h00, wake_hit}, 8'h00);
		accel_delta = 8'h11;
		@(negedge ref_clk_i);
		check("hit", {7'h00, wake_hit}, 8'h01);
		gyro_off = 1'b0;
		@(negedge ref_clk_i);
		check("hit", {7'h00, wake_hit}, 8'h00);
		$display("test threshold done");
	endtask
	task automatic run_queue(input logic [7:0] en);
		logic [7:0] exp_q[$];
		logic [7:0] v;
		u_motion_host_model.write_read(QUEUE_SOURCE_ENABLE_ADDR, en, v);
		check("queue_en", v, en & 8'hF8);
		got_q.delete();
		tick_count = 0;
		// Second sample tick lands inside the burst and must be dropped
		for (int i = 0; i < 8; i++) begin
			filter_tick = 1'b1;
			@(negedge ref_clk_i);
			filter_tick = 1'b0;
			@(negedge ref_clk_i);
		end
		repeat (20) @(negedge ref_clk_i);
		check("ticks", 8'(tick_count), 8'h02);
		for (int s = 0; s < 14; s++) begin
			if (en[s < 6 ? 3 : s < 8 ? 7 : 10 - s / 2]) exp_q.push_back(8'(s + 1));
		end
		check("bytes", 8'(got_q.size()), 8'(exp_q.size()));
		foreach (exp_q[i]) check("byte", got_q[i], exp_q[i]);
		$display("test queue %h done", en);
	endtask
	task automatic test_frame_sync();
		fs_en = 1'b1;
		fs_pin = 1'b1;
		repeat (8) @(negedge ref_clk_i);
		check("fs_flag", {7'h00, fs_flag}, 8'h01);
		u_motion_host_model.write_reg(FRAME_SYNC_IRQ_STATUS_ADDR, 8'h00);
		rd_chk("fs_status", FRAME_SYNC_IRQ_STATUS_ADDR, 8'h80);
		check("fs_flag", {7'h00, fs_flag}, 8'h00);
		rd_chk("fs_status", FRAME_SYNC_IRQ_STATUS_ADDR, 8'h00);
		fs_low = 1'b1;
		fs_pin = 1'b0;
		repeat (8) @(negedge ref_clk_i);
		rd_chk("fs_status", FRAME_SYNC_IRQ_STATUS_ADDR, 8'h80);
		fs_en = 1'b0;
		fs_pin = 1'b1;
		repeat (8) @(negedge ref_clk_i);
		fs_pin = 1'b0;
		u_motion_host_model.write_reg(FRAME_SYNC_IRQ_STATUS_ADDR, 8'hFF);
		repeat (8) @(negedge ref_clk_i);
		rd_chk("fs_status", FRAME_SYNC_IRQ_STATUS_ADDR, 8'h00);
		$display("test frame sync done");
	endtask

	initial begin
		repeat (12) @(negedge ref_clk_i);
		sys_rst_i = 1'b0;
		test_reset();
		test_low_power();
		test_wake_rate();
		test_threshold();
		run_queue(8'hFF);
		run_queue(8'h0F);
		gyro_off = 1'b1;
		run_queue(8'h90);
		test_frame_sync();
		summarize();
	end
endmodule
`default_nettype wire
